/* File: fbdf_pkg.sv */
package fbdf_pkg;
  localparam int WORD_W = 32;
  localparam logic [31:0] ONES_WORD = 32'hffffffff;
  // Low words of the two-word delimiters; the high word is always all ones
  localparam logic [31:0] FIELD_ONE_START_CODE_LO = 32'h40000000;
  localparam logic [31:0] FIELD_TWO_START_CODE_LO = 32'h41000000;
  localparam logic [31:0] SEQUENCE_END_CODE_LO = 32'hc0ffffff;
  localparam int CODE_HI = 31;
  localparam int CODE_LO = 24;
  localparam int QW_HI = 23;
  localparam int QW_LO = 8;
  localparam int QW_W = 16;
  localparam logic [7:0] BLOCK_START_M1_CHROMA = 8'h81;
  localparam logic [7:0] BLOCK_START_M1_LUMA = 8'h82;
  localparam logic [7:0] BLOCK_START_M2_CHROMA = 8'h83;
  localparam logic [7:0] BLOCK_START_M2_LUMA = 8'h84;
  localparam logic [7:0] BLOCK_START_ZERO = 8'h8f;
  localparam logic [7:0] FIRST_BLOCK_M1_CHROMA_TYPE = 8'h81;
  localparam logic [7:0] FIRST_BLOCK_M1_LUMA_TYPE = 8'h82;
  localparam logic [7:0] FIRST_BLOCK_M2_CHROMA_TYPE = 8'h83;
  localparam logic [7:0] FIRST_BLOCK_M2_LUMA_TYPE = 8'h84;
  localparam int TC_BITS = 96;
  localparam int TC_CONTENT_BITS = 90;
  localparam int TC_WORDS = TC_BITS / WORD_W;
  localparam int TC_CNT_W = 2;
  localparam int BLOCKS_PER_FIELD = 41;
  localparam int BLK_IDX_W = 6;
  localparam int BUF_DEPTH = 2;
  typedef enum logic [2:0] {
    KIND_NONE, KIND_FIELD_ONE, KIND_FIELD_TWO, KIND_SEQ_END, KIND_BLOCK, KIND_BLOCK_ZERO
  } fbdf_kind_t;
  typedef enum logic [1:0] {
    MODEL1_CHROMA, MODEL1_LUMA, MODEL2_CHROMA, MODEL2_LUMA
  } fbdf_model_t;
endpackage

/* File: fbdf_cls_if.sv */
`timescale 1ns/10ps
interface fbdf_cls_if;
  import fbdf_pkg::*;
  logic [WORD_W-1:0] word;
  logic is_ones;
  fbdf_kind_t kind;
  fbdf_model_t model;
  logic [QW_W-1:0] qwidth;
  modport cls (input word, output is_ones, output kind, output model, output qwidth);
  modport user (output word, input is_ones, input kind, input model, input qwidth);
endinterface

/* File: fbdf_classify.sv */
`timescale 1ns/10ps
module fbdf_classify (
  fbdf_cls_if.cls c
);
  import fbdf_pkg::*;

  always_comb
  begin
    c.is_ones = (c.word == ONES_WORD);
    c.qwidth = c.word[QW_HI:QW_LO];
    c.model = MODEL1_CHROMA;
    c.kind = KIND_NONE;
    if (c.word == FIELD_ONE_START_CODE_LO)
    begin
      c.kind = KIND_FIELD_ONE;
    end
    else if (c.word == FIELD_TWO_START_CODE_LO)
    begin
      c.kind = KIND_FIELD_TWO;
    end
    else if (c.word == SEQUENCE_END_CODE_LO)
    begin
      c.kind = KIND_SEQ_END;
    end
    else
    begin
      // Block start bytes and first-block type bytes share one coding
      case (c.word[CODE_HI:CODE_LO])
        BLOCK_START_M1_CHROMA:
        begin
          c.kind = KIND_BLOCK;
          c.model = MODEL1_CHROMA;
        end
        BLOCK_START_M1_LUMA:
        begin
          c.kind = KIND_BLOCK;
          c.model = MODEL1_LUMA;
        end
        BLOCK_START_M2_CHROMA:
        begin
          c.kind = KIND_BLOCK;
          c.model = MODEL2_CHROMA;
        end
        BLOCK_START_M2_LUMA:
        begin
          c.kind = KIND_BLOCK;
          c.model = MODEL2_LUMA;
        end
        BLOCK_START_ZERO: c.kind = KIND_BLOCK_ZERO;
        default: c.kind = KIND_NONE;
      endcase
    end
  end
endmodule

/* File: fbdf_buf.sv */
`timescale 1ns/10ps
module fbdf_buf #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 2
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_in_data,
  input wire logic i_in_valid,
  output logic o_in_ready,
  output logic [WIDTH-1:0] o_out_data,
  output logic o_out_valid,
  input wire logic i_out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
      $error("fbdf_buf depth must be a power of two, at least two");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [PW:0] cnt;
  } fbdf_buf_t;

  fbdf_buf_t state_ff;
  fbdf_buf_t nxt_state;
  logic do_wr;
  logic do_rd;

  assign o_in_ready = (state_ff.cnt != (PW+1)'(DEPTH));
  assign o_out_valid = (state_ff.cnt != '0);
  assign o_out_data = state_ff.mem[state_ff.rd];
  assign do_wr = i_in_valid && o_in_ready;
  assign do_rd = o_out_valid && i_out_ready;

  always_comb
  begin
    nxt_state = state_ff;
    if (do_wr)
    begin
      nxt_state.mem[state_ff.wr] = i_in_data;
      nxt_state.wr = state_ff.wr + 1'b1;
    end
    if (do_rd)
    begin
      nxt_state.rd = state_ff.rd + 1'b1;
    end
    nxt_state.cnt = state_ff.cnt + (PW+1)'(do_wr) - (PW+1)'(do_rd);
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end
endmodule

/* File: fbdf_framer.sv */
`timescale 1ns/10ps
module fbdf_framer #(
  parameter int BLOCKS = fbdf_pkg::BLOCKS_PER_FIELD
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [fbdf_pkg::WORD_W-1:0] i_rx_data,
  input wire logic i_rx_valid,
  output logic o_rx_ready,
  output logic [fbdf_pkg::WORD_W-1:0] o_data,
  output logic o_data_lead,
  output logic o_data_valid,
  input wire logic i_data_ready,
  output logic o_in_field,
  output logic o_field_start,
  output logic o_field_id,
  output logic [fbdf_pkg::TC_BITS-1:0] o_timecode,
  output logic o_timecode_valid,
  output logic o_block_start,
  output logic [fbdf_pkg::BLK_IDX_W-1:0] o_block_index,
  output fbdf_pkg::fbdf_model_t o_block_model,
  output logic o_block_zero,
  output logic [fbdf_pkg::QW_W-1:0] o_quant_width,
  output logic o_huff_reset,
  output logic o_seq_end,
  output logic o_block_count_err
);
  import fbdf_pkg::*;

  generate
    if (BLOCKS < 1 || BLOCKS >= (1 << BLK_IDX_W))
    begin : g_bad_blocks
      $error("fbdf_framer block count does not fit the index width");
    end
  endgenerate

  typedef enum {ST_IDLE, ST_TC, ST_TYPE, ST_DATA} fbdf_st_t;

  typedef struct packed {
    fbdf_st_t st;
    logic prev_ones;
    logic [TC_CNT_W-1:0] tc_cnt;
    logic [TC_BITS-1:0] tc;
    logic in_field;
    logic field_two;
    logic [BLK_IDX_W-1:0] blk_idx;
    logic [BLK_IDX_W-1:0] blk_cnt;
    fbdf_model_t model;
    logic zero;
    logic [QW_W-1:0] qw;
    logic held_vld;
    logic held_lead;
    logic [WORD_W-1:0] held;
    logic field_start;
    logic tc_vld;
    logic blk_start;
    logic huff_rst;
    logic seq_end;
    logic cnt_err;
  } fbdf_state_t;

  fbdf_state_t state_ff;
  fbdf_state_t nxt_state;
  fbdf_cls_if cls ();
  logic buf_in_ready;
  logic accept;
  logic delim;
  logic emit_en;
  logic push;

  // Opens a block: index from position, model and width from the code word except for a zero block (MODEL1_CHROMA, zero width)
  function automatic fbdf_state_t begin_block(fbdf_state_t s, logic zero,
                                              fbdf_model_t m, logic [QW_W-1:0] qw,
                                              logic [WORD_W-1:0] w);
    fbdf_state_t r;
    r = s;
    r.st = ST_DATA;
    r.blk_idx = s.blk_cnt;
    if (s.blk_cnt == BLK_IDX_W'(BLOCKS))
    begin
      r.cnt_err = 1'b1;
    end
    else
    begin
      r.blk_cnt = s.blk_cnt + 1'b1;
    end
    r.blk_start = 1'b1;
    r.huff_rst = 1'b1;
    r.zero = zero;
    r.model = zero ? MODEL1_CHROMA : m;
    r.qw = zero ? '0 : qw;
    r.held = w;
    r.held_vld = 1'b1;
    r.held_lead = 1'b1;
    return r;
  endfunction

  // A field that closes with the wrong number of blocks is flagged
  function automatic logic count_bad(fbdf_state_t s);
    return s.in_field && (s.blk_cnt != BLK_IDX_W'(BLOCKS));
  endfunction

  assign cls.word = i_rx_data;

  fbdf_classify u_classify (
    .c(cls)
  );

  fbdf_buf #(
    .WIDTH(WORD_W + 1),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_in_data({state_ff.held_lead, state_ff.held}),
    .i_in_valid(push),
    .o_in_ready(buf_in_ready),
    .o_out_data({o_data_lead, o_data}),
    .o_out_valid(o_data_valid),
    .i_out_ready(i_data_ready)
  );

  // Stall the host while the buffer is full so no word is dropped
  assign o_rx_ready = buf_in_ready;
  assign accept = i_rx_valid && buf_in_ready;
  // Timecode words are never taken as delimiter halves
  assign delim = accept && state_ff.prev_ones && (state_ff.st != ST_TC)
                 && (cls.kind != KIND_NONE);
  assign emit_en = (state_ff.st == ST_DATA) && !state_ff.zero
                   && (state_ff.qw != '0);
  // Held word goes out, except in a zero block or one of zero width, once the next word proves it is no delimiter prefix
  assign push = accept && state_ff.held_vld && !delim && emit_en;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.field_start = 1'b0;
    nxt_state.tc_vld = 1'b0;
    nxt_state.blk_start = 1'b0;
    nxt_state.huff_rst = 1'b0;
    nxt_state.seq_end = 1'b0;
    nxt_state.cnt_err = 1'b0;
    if (accept)
    begin
      nxt_state.prev_ones = (state_ff.st != ST_TC) && cls.is_ones;
      if (push)
      begin
        nxt_state.held_vld = 1'b0;
      end
      if (delim)
      begin
        nxt_state.held_vld = 1'b0;
        case (cls.kind)
          KIND_FIELD_ONE, KIND_FIELD_TWO:
          begin
            nxt_state.cnt_err = count_bad(state_ff);
            nxt_state.in_field = 1'b1;
            nxt_state.field_two = (cls.kind == KIND_FIELD_TWO);
            nxt_state.field_start = 1'b1;
            nxt_state.huff_rst = 1'b1;
            nxt_state.st = ST_TC;
            nxt_state.tc_cnt = '0;
            nxt_state.blk_cnt = '0;
            nxt_state.prev_ones = 1'b0;
          end
          KIND_SEQ_END:
          begin
            nxt_state.cnt_err = count_bad(state_ff);
            nxt_state.in_field = 1'b0;
            nxt_state.seq_end = 1'b1;
            nxt_state.huff_rst = 1'b1;
            nxt_state.st = ST_IDLE;
          end
          KIND_BLOCK, KIND_BLOCK_ZERO:
          begin
            if (state_ff.st == ST_DATA || state_ff.st == ST_TYPE)
            begin
              nxt_state = begin_block(nxt_state, cls.kind == KIND_BLOCK_ZERO,
                                      cls.model, cls.qwidth, i_rx_data);
            end
            else
            begin
              nxt_state.huff_rst = 1'b1;
            end
          end
          default: nxt_state.st = state_ff.st;
        endcase
      end
      else
      begin
        case (state_ff.st)
          ST_TC:
          begin
            nxt_state.tc = {state_ff.tc[TC_BITS-WORD_W-1:0], i_rx_data};
            nxt_state.tc_cnt = state_ff.tc_cnt + 1'b1;
            if (state_ff.tc_cnt == TC_CNT_W'(TC_WORDS - 1))
            begin
              nxt_state.tc_vld = 1'b1;
              nxt_state.st = ST_TYPE;
            end
          end
          ST_TYPE:
          begin
            if (cls.kind == KIND_BLOCK)
            begin
              nxt_state = begin_block(nxt_state, 1'b0, cls.model, cls.qwidth,
                                      i_rx_data);
            end
            else
            begin
              nxt_state.st = ST_IDLE;
            end
          end
          ST_DATA:
          begin
            nxt_state.held = i_rx_data;
            nxt_state.held_vld = 1'b1;
            nxt_state.held_lead = 1'b0;
          end
          default: nxt_state.st = state_ff.st;
        endcase
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state_ff <= '{st: ST_IDLE, model: MODEL1_CHROMA, default: '0};
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign o_in_field = state_ff.in_field;
  assign o_field_start = state_ff.field_start;
  assign o_field_id = state_ff.field_two;
  assign o_timecode = state_ff.tc;
  assign o_timecode_valid = state_ff.tc_vld;
  assign o_block_start = state_ff.blk_start;
  assign o_block_index = state_ff.blk_idx;
  assign o_block_model = state_ff.model;
  assign o_block_zero = state_ff.zero;
  assign o_quant_width = state_ff.qw;
  assign o_huff_reset = state_ff.huff_rst;
  assign o_seq_end = state_ff.seq_end;
  assign o_block_count_err = state_ff.cnt_err;
endmodule

/* File: fbdf_framer_properties.sv */
`timescale 1ns/10ps
module fbdf_framer_chk
  import fbdf_pkg::*;
#(
  parameter int BLOCKS = 41
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [fbdf_pkg::WORD_W-1:0] i_rx_data,
  input wire logic i_rx_valid,
  input wire logic o_rx_ready,
  input wire logic [fbdf_pkg::WORD_W-1:0] o_data,
  input wire logic o_data_valid,
  input wire logic i_data_ready,
  input wire logic o_in_field,
  input wire logic o_field_start,
  input wire logic o_field_id,
  input wire logic o_timecode_valid,
  input wire logic o_block_start,
  input wire logic [fbdf_pkg::BLK_IDX_W-1:0] o_block_index,
  input fbdf_pkg::fbdf_model_t o_block_model,
  input wire logic o_block_zero,
  input wire logic [fbdf_pkg::QW_W-1:0] o_quant_width,
  input wire logic o_huff_reset,
  input wire logic o_seq_end
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);
  chk_field_reset: assert property (o_field_start |-> o_huff_reset)
    else $error("field start without decoder reset");
  chk_field_code: assert property (o_field_start |-> $past(i_rx_valid && o_rx_ready &&
    (i_rx_data == FIELD_ONE_START_CODE_LO || i_rx_data == FIELD_TWO_START_CODE_LO)))
    else $error("field start without a field code taken");
  chk_field_ident: assert property (o_field_start |->
    o_field_id == ($past(i_rx_data) == FIELD_TWO_START_CODE_LO))
    else $error("field identity does not follow the code");
  chk_block_reset: assert property (o_block_start |-> o_huff_reset)
    else $error("block start without decoder reset");
  chk_zero_block: assert property (o_block_start |->
    o_block_zero == ($past(i_rx_data[CODE_HI:CODE_LO]) == BLOCK_START_ZERO) &&
    (!o_block_zero || (o_quant_width == 16'h0000 && o_block_model == MODEL1_CHROMA)))
    else $error("zero block reported wrongly");
  chk_block_width: assert property (o_block_start && !o_block_zero |->
    o_quant_width == $past(i_rx_data[QW_HI:QW_LO]) &&
    o_block_model == fbdf_model_t'($past(i_rx_data[25:24]) - 2'h1))
    else $error("block width or model wrong");
  chk_block_order: assert property (o_block_start && o_block_index != 6'h00 |->
    o_block_index == $past(o_block_index) + 6'h01)
    else $error("block index not in sequence");
  chk_tc_take: assert property (o_timecode_valid |-> $past(i_rx_valid && o_rx_ready))
    else $error("timecode valid without a word taken");
  chk_seq_close: assert property (o_seq_end |-> o_huff_reset && !o_in_field &&
    $past(i_rx_data) == SEQUENCE_END_CODE_LO)
    else $error("sequence end reported wrongly");
  chk_out_hold: assert property (o_data_valid && !i_data_ready |=>
    o_data_valid && $stable(o_data))
    else $error("output word dropped during stall");
endmodule
bind fbdf_framer fbdf_framer_chk #(.BLOCKS(BLOCKS)) u_chk (
  .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_rx_data(i_rx_data),
  .i_rx_valid(i_rx_valid), .o_rx_ready(o_rx_ready), .o_data(o_data),
  .o_data_valid(o_data_valid), .i_data_ready(i_data_ready), .o_in_field(o_in_field),
  .o_field_start(o_field_start), .o_field_id(o_field_id),
  .o_timecode_valid(o_timecode_valid), .o_block_start(o_block_start),
  .o_block_index(o_block_index), .o_block_model(o_block_model),
  .o_block_zero(o_block_zero), .o_quant_width(o_quant_width),
  .o_huff_reset(o_huff_reset), .o_seq_end(o_seq_end)
);

/* File: fbdf_host_model.sv */
`timescale 1ns/10ps
module fbdf_host_model (
  input wire logic i_core_clk,
  input wire logic i_ready,
  output logic [31:0] o_data,
  output logic o_valid
);
  initial
  begin
    o_valid = 1'b0;
    o_data = 32'h00000000;
  end
  // Whole aligned words only, held until taken
  task automatic send(input logic [31:0] w);
    int n;
    @(negedge i_core_clk);
    o_data = w;
    o_valid = 1'b1;
    n = 0;
    while (i_ready !== 1'b1 && n < 300)
    begin
      @(negedge i_core_clk);
      n++;
    end
    if (i_ready !== 1'b1)
    begin
      tb_top.bad_count++;
      tb_top.stop_test();
    end
    @(posedge i_core_clk);
  endtask
  // Released lines show no stale word
  task automatic pause();
    @(negedge i_core_clk);
    o_valid = 1'b0;
    o_data = ~o_data;
  endtask
endmodule

/* File: tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import fbdf_pkg::*;
  localparam int NB = 5;
  logic i_core_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_data_ready = 1'b0;
  logic [31:0] rx_data, o_data;
  logic rx_valid, rx_ready, o_data_lead, o_data_valid, o_in_field, o_field_start, o_field_id;
  logic [95:0] o_timecode;
  logic o_timecode_valid, o_block_start, o_block_zero, o_huff_reset, o_seq_end, o_cnt_err;
  logic [5:0] o_block_index;
  fbdf_model_t o_block_model;
  logic [15:0] o_quant_width;
  int bad_count = 0;
  int n_checks = 0;
  int seed = 32'hdc42;
  int seq_ends = 0;
  int cnt_errs = 0;
  int fcnt = 0;
  int huff_cnt = 0;
  logic [32:0] data_q[$];
  logic [24:0] blk_q[$];
  logic fld_q[$];
  logic [95:0] tc_q[$];
  always #25 i_core_clk = ~i_core_clk;
  fbdf_framer #(.BLOCKS(NB)) DUT (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_rx_data(rx_data),
    .i_rx_valid(rx_valid), .o_rx_ready(rx_ready), .o_data(o_data), .o_data_lead(o_data_lead),
    .o_data_valid(o_data_valid), .i_data_ready(i_data_ready), .o_in_field(o_in_field),
    .o_field_start(o_field_start), .o_field_id(o_field_id), .o_timecode(o_timecode),
    .o_timecode_valid(o_timecode_valid), .o_block_start(o_block_start),
    .o_block_index(o_block_index), .o_block_model(o_block_model), .o_block_zero(o_block_zero),
    .o_quant_width(o_quant_width), .o_huff_reset(o_huff_reset), .o_seq_end(o_seq_end),
    .o_block_count_err(o_cnt_err)
  );
  fbdf_host_model host (
    .i_core_clk(i_core_clk), .i_ready(rx_ready), .o_data(rx_data), .o_valid(rx_valid)
  );
  task automatic cmp(input logic [95:0] got, input logic [95:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(negedge i_core_clk)
    i_data_ready <= ($random(seed) & 7) > 2;
  always @(posedge i_core_clk)
  begin
    if (o_data_valid === 1'b1 && i_data_ready)
      cmp({o_data_lead, o_data}, data_q.size() ? data_q.pop_front() : 'x);
    if (o_block_start === 1'b1)
      cmp({o_block_zero, o_block_model, o_block_index, o_quant_width},
        blk_q.size() ? blk_q.pop_front() : 'x);
    if (o_field_start === 1'b1)
      cmp(o_field_id, fld_q.size() ? fld_q.pop_front() : 'x);
    if (o_timecode_valid === 1'b1)
      cmp(o_timecode, tc_q.size() ? tc_q.pop_front() : 'x);
    if (o_seq_end === 1'b1)
      seq_ends++;
    if (o_cnt_err === 1'b1)
      cnt_errs++;
    if (o_huff_reset === 1'b1)
      huff_cnt++;
  end
  task automatic send_field(input logic f2, input int nblk);
    logic [95:0] tc;
    logic [7:0] code;
    logic [15:0] w;
    logic [31:0] cw, dw;
    logic zero;
    int nd;
    host.send(32'hffffffff);
    host.send(f2 ? FIELD_TWO_START_CODE_LO : FIELD_ONE_START_CODE_LO);
    fld_q.push_back(f2);
    tc = {$random(seed), $random(seed), $random(seed)};
    tc_q.push_back(tc);
    for (int i = 0; i < 3; i++)
      host.send(tc[95 - 32 * i -: 32]);
    for (int b = 0; b < nblk; b++)
    begin
      code = (b == 3) ? BLOCK_START_ZERO : 8'h81 + 8'((b + fcnt) % 4);
      w = (b == 1) ? 16'h0000 : 16'($random(seed));
      cw = {code, w, 8'($random(seed))};
      zero = code == BLOCK_START_ZERO;
      if (b > 0)
        host.send(32'hffffffff);
      host.send(cw);
      blk_q.push_back({zero, zero ? MODEL1_CHROMA : fbdf_model_t'(code[1:0] - 2'h1),
        6'(b), zero ? 16'h0000 : w});
      if (!zero && w != 16'h0000)
        data_q.push_back({1'b1, cw});
      nd = 1 + $unsigned($random(seed)) % 3;
      for (int d = 0; d < nd; d++)
      begin
        dw = {1'b0, 31'($random(seed))} | ((d == nd - 1) ? 32'h0000ffff : 32'h0);
        host.send(dw);
        if (!zero && w != 16'h0000)
          data_q.push_back({1'b0, dw});
      end
      if (b == 2)
        host.pause();
    end
    fcnt++;
  endtask
  initial
  begin
    repeat (4) @(negedge i_core_clk);
    i_sys_rst = 1'b0;
    send_field(1'b0, NB);
    send_field(1'b1, NB - 1);
    send_field(1'b0, NB);
    send_field(1'b1, NB);
    host.send(32'hffffffff);
    host.send(SEQUENCE_END_CODE_LO);
    host.send(32'hffffffff);
    host.send({BLOCK_START_M1_LUMA, 24'h000100});
    host.pause();
    for (int n = 0; n < 500 && data_q.size() > 0; n++)
      @(negedge i_core_clk);
    repeat (4) @(negedge i_core_clk);
    cmp(seq_ends, 1);
    cmp(cnt_errs, 1);
    // Four field starts, every block start, the sequence end and the stray start in idle
    cmp(huff_cnt, 4 * NB + 5);
    cmp(o_in_field, 1'b0);
    cmp(blk_q.size() + fld_q.size() + tc_q.size() + data_q.size(), 0);
    stop_test();
  end
endmodule
